// >>> src/edmb_consts.svh
`ifndef EDMB_CONSTS_SVH
`define EDMB_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EDMB_OFS_CTRL       4'h0
`define EDMB_OFS_LOAD_ADDR  4'h4
`define EDMB_OFS_LOAD_DATA  4'h8
`define EDMB_OFS_STATUS     4'hC

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define EDMB_CTRL_WIDTH_LSB 0
`define EDMB_CTRL_DUAL      2
`define EDMB_CTRL_SCHEME    3
`define EDMB_CTRL_LUT       4
`define EDMB_CTRL_CLEAR     5

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define EDMB_RST_WIDTH      2'h0
`define EDMB_RST_DUAL       1'h1
`define EDMB_RST_SCHEME     1'h0
`define EDMB_RST_LUT        1'h0
`define EDMB_RESP_OKAY      2'h0
`define EDMB_RESP_SLVERR    2'h2

`endif

// >>> src/edmb_pkg.sv
package edmb_pkg;

  // ----------------------------------------------------------------
  // basic types
  // ----------------------------------------------------------------
  typedef logic [10:0] edmb_addr_t;   // user address, up to 2048 words
  typedef logic [15:0] edmb_data_t;   // widest data word
  typedef logic [7:0]  edmb_word_t;   // physical row of the array
  typedef logic [3:0]  edmb_shift_t;  // lane offset inside a row

  // memory shapes
  typedef enum logic [1:0]
  {
    EDMB_W16 = 2'h0,  // 256 x 16
    EDMB_W8  = 2'h1,  // 512 x 8
    EDMB_W4  = 2'h2,  // 1024 x 4
    EDMB_W2  = 2'h3   // 2048 x 2
  } edmb_width_e;

  // ----------------------------------------------------------------
  // state of the top module
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic        aw_ready;
    logic        aw_got;
    logic [3:0]  aw_addr;
    logic        w_ready;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        ar_ready;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    edmb_width_e width;
    logic        dual;
    logic        scheme;
    logic        lookup_table;
    edmb_word_t  load_addr;
    logic        load_pend;
    edmb_data_t  load_data;
    edmb_word_t  wa_word;
    edmb_data_t  wa_data;
    edmb_data_t  wa_mask;
    logic        wr_pend;
    edmb_word_t  ra_word;
    edmb_shift_t ra_shift;
    edmb_data_t  ra_mask;
    logic        rd_en_q;
  } edmb_state_s;

  // state of the array module
  typedef struct packed
  {
    edmb_data_t r_data;
  } edmb_mem_state_s;

  // ----------------------------------------------------------------
  // address decoding per shape
  // ----------------------------------------------------------------
  function automatic edmb_word_t edmb_word_of(input edmb_addr_t  a,
                                              input edmb_width_e w);
    case (w)
      EDMB_W8:  return a[8:1];
      EDMB_W4:  return a[9:2];
      EDMB_W2:  return a[10:3];
      default:  return a[7:0];
    endcase
  endfunction : edmb_word_of

  function automatic edmb_shift_t edmb_shift_of(input edmb_addr_t  a,
                                                input edmb_width_e w);
    case (w)
      EDMB_W8:  return {a[0], 3'h0};
      EDMB_W4:  return {a[1:0], 2'h0};
      EDMB_W2:  return {a[2:0], 1'h0};
      default:  return 4'h0;
    endcase
  endfunction : edmb_shift_of

  function automatic edmb_data_t edmb_mask_of(input edmb_width_e w);
    case (w)
      EDMB_W8:  return 16'h00FF;
      EDMB_W4:  return 16'h000F;
      EDMB_W2:  return 16'h0003;
      default:  return 16'hFFFF;
    endcase
  endfunction : edmb_mask_of

endpackage : edmb_pkg

// >>> src/edmb_mem_array.sv
`timescale 1ns/100ps

module edmb_mem_array
  import edmb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clr,
  input  wire logic        we,
  input  wire edmb_word_t  w_word,
  input  wire edmb_data_t  w_data,
  input  wire edmb_data_t  w_mask,
  input  wire logic        re,
  input  wire edmb_word_t  r_word,
  input  wire edmb_shift_t r_shift,
  input  wire edmb_data_t  r_mask,
  output edmb_data_t       r_data
);

  // ----------------------------------------------------------------
  // storage and output register
  // ----------------------------------------------------------------
  edmb_data_t      mem [0:255];  // 256 rows of 16 bits
  edmb_mem_state_s st;           // registered state
  edmb_mem_state_s nx;           // next state

  assign r_data = st.r_data;

  // output register: lane picked out, old contents on collision
  always_comb
  begin
    nx = st;
    if (clr)
    begin
      nx.r_data = 16'h0000;
    end
    else if (re)
    begin
      nx.r_data = edmb_data_t'((mem[r_word] >> r_shift) & r_mask);
    end
  end

  // register state and write the array on the internal strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
    if (we)
    begin
      mem[w_word] <= (mem[w_word] & ~w_mask) | (w_data & w_mask);
    end
  end

endmodule : edmb_mem_array

// >>> src/edmb_top.sv
// Overview of operation
// - block stores 4096 bits in total
// - data words up to sixteen bits
// - single shared port or separate ports
// - write and read sides clocked separately
// - each side has its own clock enable
// - or input and output registers clocked separately
// - inputs and output data are registered
// - lookup table preloaded, read only in use
// - lookup table: eight inputs, sixteen outputs
// - shapes 256x16, 512x8, 1024x4, 2048x2
// - write strobe generated internally after capture
// - data path and output registers clearable by clear or reset
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "edmb_consts.svh"

module edmb_top
(
  input  wire logic          CLK,
  input  wire logic          RESET,
  input  wire logic [3:0]    S_AXI_AWADDR,
  input  wire logic          S_AXI_AWVALID,
  output logic               S_AXI_AWREADY,
  input  wire logic [31:0]   S_AXI_WDATA,
  input  wire logic [3:0]    S_AXI_WSTRB,
  input  wire logic          S_AXI_WVALID,
  output logic               S_AXI_WREADY,
  output logic [1:0]         S_AXI_BRESP,
  output logic               S_AXI_BVALID,
  input  wire logic          S_AXI_BREADY,
  input  wire logic [3:0]    S_AXI_ARADDR,
  input  wire logic          S_AXI_ARVALID,
  output logic               S_AXI_ARREADY,
  output logic [31:0]        S_AXI_RDATA,
  output logic [1:0]         S_AXI_RRESP,
  output logic               S_AXI_RVALID,
  input  wire logic          S_AXI_RREADY,
  input  wire logic          CLR,
  input  wire logic          WR_TICK,
  input  wire logic          WR_CE,
  input  wire logic          WR_EN,
  input  wire edmb_pkg::edmb_addr_t WR_ADDR,
  input  wire edmb_pkg::edmb_data_t WR_DATA,
  input  wire logic          RD_TICK,
  input  wire logic          RD_CE,
  input  wire logic          RD_EN,
  input  wire edmb_pkg::edmb_addr_t RD_ADDR,
  output edmb_pkg::edmb_data_t      DOUT
);
  import edmb_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  edmb_state_s st;          // registered state
  edmb_state_s nx;          // next state
  logic        wr_do;       // both write channels held, answer now
  logic        soft_clear;  // clear pulse written by software
  logic        clr;         // data path clear
  logic        wr_stb;      // write or input clock edge
  logic        rd_stb;      // read or output clock edge
  logic        in_rd_stb;   // edge that captures the read address
  logic        out_stb;     // edge that loads the output register
  edmb_addr_t  rd_src;      // read address source
  edmb_width_e eff_w;       // shape in use
  logic        mem_we;      // internal write strobe
  edmb_word_t  mem_word;    // row written
  edmb_data_t  mem_data;    // data written
  edmb_data_t  mem_mask;    // bits written

  // ----------------------------------------------------------------
  // side strobes and port selection
  // ----------------------------------------------------------------
  assign wr_stb    = WR_TICK && WR_CE;
  assign rd_stb    = RD_TICK && RD_CE;
  assign in_rd_stb = (!st.dual || st.scheme) ? wr_stb : rd_stb;
  assign out_stb   = (st.dual || st.scheme) ? rd_stb : wr_stb;
  assign rd_src    = st.dual ? RD_ADDR : WR_ADDR;
  assign eff_w     = st.lookup_table ? EDMB_W16 : st.width;
  assign wr_do     = st.aw_got && st.w_got && !st.b_valid;
  assign soft_clear = wr_do && (st.aw_addr == `EDMB_OFS_CTRL)
                      && st.w_strb[0] && st.w_data[`EDMB_CTRL_CLEAR];
  assign clr       = CLR || soft_clear;

  // ----------------------------------------------------------------
  // array write source: loader first, else user write
  // ----------------------------------------------------------------
  assign mem_we   = st.load_pend || st.wr_pend;
  assign mem_word = st.load_pend ? st.load_addr : st.wa_word;
  assign mem_data = st.load_pend ? st.load_data : st.wa_data;
  assign mem_mask = st.load_pend ? 16'hFFFF : st.wa_mask;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nx = st;
    // write address and data channels, taken in either order
    if (S_AXI_AWVALID && st.aw_ready)
    begin
      nx.aw_got  = 1'b1;
      nx.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st.w_ready)
    begin
      nx.w_got  = 1'b1;
      nx.w_data = S_AXI_WDATA;
      nx.w_strb = S_AXI_WSTRB;
    end
    if (st.b_valid && S_AXI_BREADY)
    begin
      nx.b_valid = 1'b0;
    end
    nx.load_pend = 1'b0;
    if (st.load_pend)
    begin
      nx.load_addr = edmb_word_t'(st.load_addr + 8'h01);
    end
    // register write
    if (wr_do)
    begin
      nx.aw_got  = 1'b0;
      nx.w_got   = 1'b0;
      nx.b_valid = 1'b1;
      nx.b_resp  = `EDMB_RESP_OKAY;
      case (st.aw_addr)
        `EDMB_OFS_CTRL:
        begin
          if (st.w_strb[0])
          begin
            nx.width  = edmb_width_e'(st.w_data[`EDMB_CTRL_WIDTH_LSB +: 2]);
            nx.dual   = st.w_data[`EDMB_CTRL_DUAL];
            nx.scheme = st.w_data[`EDMB_CTRL_SCHEME];
            nx.lookup_table    = st.w_data[`EDMB_CTRL_LUT];
          end
        end
        `EDMB_OFS_LOAD_ADDR:
        begin
          if (st.w_strb[0])
          begin
            nx.load_addr = st.w_data[7:0];
          end
        end
        `EDMB_OFS_LOAD_DATA:
        begin
          // preload only while in lookup-table use
          if (st.lookup_table && (st.w_strb[1:0] != 2'h0))
          begin
            nx.load_pend = 1'b1;
            nx.load_data = st.w_data[15:0];
          end
        end
        `EDMB_OFS_STATUS:
        begin
          nx.b_resp = `EDMB_RESP_OKAY;  // read only, write ignored
        end
        default:
        begin
          nx.b_resp = `EDMB_RESP_SLVERR;  // unmapped
        end
      endcase
    end
    nx.aw_ready = !nx.aw_got && !nx.b_valid;
    nx.w_ready  = !nx.w_got && !nx.b_valid;
    // register read
    if (st.r_valid && S_AXI_RREADY)
    begin
      nx.r_valid  = 1'b0;
      nx.ar_ready = 1'b1;
    end
    if (S_AXI_ARVALID && st.ar_ready)
    begin
      nx.ar_ready = 1'b0;
      nx.r_valid  = 1'b1;
      nx.r_resp   = `EDMB_RESP_OKAY;
      case (S_AXI_ARADDR)
        `EDMB_OFS_CTRL:
          nx.r_data = {27'h000_0000, st.lookup_table, st.scheme, st.dual, st.width};
        `EDMB_OFS_LOAD_ADDR:
          nx.r_data = {24'h00_0000, st.load_addr};
        `EDMB_OFS_LOAD_DATA:
          nx.r_data = {16'h0000, st.load_data};
        `EDMB_OFS_STATUS:
          nx.r_data = {14'h0000, st.wr_pend, st.rd_en_q, DOUT};
        default:
        begin
          nx.r_data = 32'h0000_0000;
          nx.r_resp = `EDMB_RESP_SLVERR;
        end
      endcase
    end
    // write side input registers, strobe one cycle later
    nx.wr_pend = 1'b0;
    if (wr_stb)
    begin
      nx.wa_word = edmb_word_of(WR_ADDR, eff_w);
      nx.wa_mask = edmb_data_t'(edmb_mask_of(eff_w)
                   << edmb_shift_of(WR_ADDR, eff_w));
      nx.wa_data = edmb_data_t'((WR_DATA & edmb_mask_of(eff_w))
                   << edmb_shift_of(WR_ADDR, eff_w));
      nx.wr_pend = WR_EN && !st.lookup_table;
    end
    // read side input registers
    if (in_rd_stb)
    begin
      nx.ra_word  = edmb_word_of(rd_src, eff_w);
      nx.ra_shift = edmb_shift_of(rd_src, eff_w);
      nx.ra_mask  = edmb_mask_of(eff_w);
      nx.rd_en_q  = RD_EN;
    end
    // clear of the data path registers
    if (clr)
    begin
      nx.wa_word  = 8'h00;
      nx.wa_data  = 16'h0000;
      nx.wa_mask  = 16'h0000;
      nx.wr_pend  = 1'b0;
      nx.ra_word  = 8'h00;
      nx.ra_shift = 4'h0;
      nx.ra_mask  = 16'h0000;
      nx.rd_en_q  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      st          <= '0;
      st.aw_ready <= 1'b1;
      st.w_ready  <= 1'b1;
      st.ar_ready <= 1'b1;
      st.width    <= edmb_width_e'(`EDMB_RST_WIDTH);
      st.dual     <= `EDMB_RST_DUAL;
      st.scheme   <= `EDMB_RST_SCHEME;
      st.lookup_table      <= `EDMB_RST_LUT;
    end
    else
    begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // storage array with registered output
  // ----------------------------------------------------------------
  edmb_mem_array u_array
  (
    .clk     (CLK),
    .reset   (RESET),
    .clr     (clr),
    .we      (mem_we),
    .w_word  (mem_word),
    .w_data  (mem_data),
    .w_mask  (mem_mask),
    .re      (out_stb && st.rd_en_q),
    .r_word  (st.ra_word),
    .r_shift (st.ra_shift),
    .r_mask  (st.ra_mask),
    .r_data  (DOUT)
  );

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  assign S_AXI_AWREADY = st.aw_ready;
  assign S_AXI_WREADY  = st.w_ready;
  assign S_AXI_BVALID  = st.b_valid;
  assign S_AXI_BRESP   = st.b_resp;
  assign S_AXI_ARREADY = st.ar_ready;
  assign S_AXI_RVALID  = st.r_valid;
  assign S_AXI_RDATA   = st.r_data;
  assign S_AXI_RRESP   = st.r_resp;

endmodule : edmb_top

// >>> verif/edmb_user.sv
`timescale 1ns/100ps

// ------
// fabric logic driving the user ports of one block
// ------
module edmb_user
(
  input  wire logic            CLK,
  output logic                 WR_TICK,
  output logic                 WR_CE,
  output logic                 WR_EN,
  output edmb_pkg::edmb_addr_t WR_ADDR,
  output edmb_pkg::edmb_data_t WR_DATA,
  output logic                 RD_TICK,
  output logic                 RD_CE,
  output logic                 RD_EN,
  output edmb_pkg::edmb_addr_t RD_ADDR
);
  import edmb_pkg::*;

  // quiet lines at time zero
  initial
  begin
    {WR_TICK, WR_CE, WR_EN, RD_TICK, RD_CE, RD_EN} = '0;
    {WR_ADDR, WR_DATA, RD_ADDR} = '0;
  end

  // one cycle; flags are {tick, ce, en}, set just after an edge
  task automatic step(input logic [2:0] w, input edmb_addr_t wa,
                      input edmb_data_t wd, input logic [2:0] r,
                      input edmb_addr_t ra);
    {WR_TICK, WR_CE, WR_EN} <= w;
    WR_ADDR <= wa;
    WR_DATA <= wd;
    {RD_TICK, RD_CE, RD_EN} <= r;
    RD_ADDR <= ra;
    @(posedge CLK);
  endtask : step

  // released lines flip so stale values never look valid
  task automatic rest;
    step(3'h0, ~WR_ADDR, ~WR_DATA, 3'h0, ~RD_ADDR);
  endtask : rest
endmodule : edmb_user

// >>> verif/edmb_top_props.sv
`timescale 1ns/100ps

module edmb_chk
(
  input wire logic                 CLK,
  input wire logic                 RESET,
  input wire logic                 S_AXI_AWVALID,
  input wire logic                 S_AXI_AWREADY,
  input wire logic                 S_AXI_WVALID,
  input wire logic                 S_AXI_WREADY,
  input wire logic                 S_AXI_BVALID,
  input wire logic                 S_AXI_BREADY,
  input wire logic [3:0]           S_AXI_ARADDR,
  input wire logic                 S_AXI_ARVALID,
  input wire logic                 S_AXI_ARREADY,
  input wire logic [31:0]          S_AXI_RDATA,
  input wire logic [1:0]           S_AXI_RRESP,
  input wire logic                 S_AXI_RVALID,
  input wire logic                 S_AXI_RREADY,
  input wire logic                 CLR,
  input wire logic                 WR_TICK,
  input wire logic                 WR_CE,
  input wire logic                 RD_TICK,
  input wire logic                 RD_CE,
  input wire edmb_pkg::edmb_data_t DOUT
);
  // ------
  // handshake shorthands
  // ------
  wire wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  wire rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  wire hold  = !(WR_TICK && WR_CE) && !(RD_TICK && RD_CE) && !CLR;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  a_write_answer: assert property (wr_go |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  a_b_busy: assert property
    (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write channel ready during response");
  a_b_done: assert property (S_AXI_BVALID && S_AXI_BREADY
    |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write response not retired");
  a_read_answer: assert property (rd_go |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read data missing");
  a_r_done: assert property (S_AXI_RVALID && S_AXI_RREADY
    |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read data not retired");
  a_unmapped_rd: assert property (rd_go && S_AXI_ARADDR[1:0] != 2'h0
    |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0000_0000)
    else $error("unaligned read not refused");
  // a software clear pulse lands on the edge that raises the write answer
  a_dout_idle: assert property (hold |=> $stable(DOUT) || $rose(S_AXI_BVALID))
    else $error("output changed without strobe");
  a_clear_dout: assert property (CLR |=> DOUT == 16'h0000)
    else $error("clear left output data");
  a_reset_dout: assert property (disable iff (1'b0)
    RESET |=> DOUT == 16'h0000)
    else $error("reset left output data");

  c_write: cover property (wr_go);
  c_read: cover property (rd_go);
  c_strobes: cover property (RD_TICK && RD_CE ##1 RD_TICK && RD_CE);
endmodule : edmb_chk

bind edmb_top edmb_chk chk_u (.*);

// >>> verif/tb.sv
`timescale 1ns/100ps
`define CMP(g, e) cmp(32'(g), 32'(e))

module tb;
  import edmb_pkg::*;
  // ------
  // pins, named as the top module's ports
  // ------
  logic          CLK = 1'b0;
  logic          RESET = 1'b1;
  logic          CLR = 1'b0;
  logic [3:0]    S_AXI_AWADDR = 4'h0;
  logic [3:0]    S_AXI_ARADDR = 4'h0;
  logic [3:0]    S_AXI_WSTRB = 4'h0;
  logic [31:0]   S_AXI_WDATA = 32'h0000_0000;
  logic          S_AXI_AWVALID = 1'b0;
  logic          S_AXI_WVALID = 1'b0;
  logic          S_AXI_BREADY = 1'b0;
  logic          S_AXI_ARVALID = 1'b0;
  logic          S_AXI_RREADY = 1'b0;
  logic          S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic          S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]    S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0]   S_AXI_RDATA, rd;
  logic          WR_TICK, WR_CE, WR_EN, RD_TICK, RD_CE, RD_EN;
  edmb_addr_t    WR_ADDR, RD_ADDR, a;
  edmb_data_t    WR_DATA, DOUT, d;
  logic [15:0]   lf = 16'hEF83;  // seed 61315
  logic [4095:0] ref_mem = '0;   // expected array bits
  logic [1:0]    rs, bs;
  int            fail_count = 0;
  int            checks_done = 0;

  edmb_top  dut_u (.*);
  edmb_user usr_u (.*);

  initial
  begin
    forever #20 CLK = ~CLK;
  end

  // ------
  // helpers
  // ------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic stall;
    fail_count++;
    give_verdict();
  endtask : stall

  function automatic logic [15:0] nxt;
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : nxt

  // expected word of shape w: lane of 16>>w bits at a*(16>>w)
  function automatic edmb_data_t want(input edmb_addr_t x, input int w);
    return edmb_data_t'(ref_mem >> (x * (16 >> w)))
           & (16'hFFFF >> (16 - (16 >> w)));
  endfunction : want

  task automatic axi_wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge CLK);
    S_AXI_AWADDR <= ad;
    S_AXI_WDATA <= dt;
    S_AXI_WSTRB <= 4'hF;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge CLK);
      if (S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID)
      begin
        bs = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
        return;
      end
    end
    stall();
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] ad);
    @(posedge CLK);
    S_AXI_ARADDR <= ad;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge CLK);
      if (S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID)
      begin
        rd = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
        return;
      end
    end
    stall();
  endtask : axi_rd

  task automatic u_wr(input edmb_addr_t x, input edmb_data_t v, input int w);
    usr_u.step(3'h7, x, v, 3'h0, ~x);
    for (int k = 0; k < (16 >> w); k++)
      ref_mem[x * (16 >> w) + k] = v[k];
  endtask : u_wr

  // both strobes serve every clocking mode; second one loads DOUT
  task automatic u_rd(input edmb_addr_t x);
    usr_u.step(3'h6, x, nxt(), 3'h7, x);
    usr_u.step(3'h6, x, nxt(), 3'h6, x);
    usr_u.rest();
  endtask : u_rd

  // ------
  // main sequence
  // ------
  initial
  begin
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    axi_rd(4'h0);
    `CMP(rd, 32'h0000_0004);
    axi_rd(4'h2);
    `CMP(rs, 2'h2);
    `CMP(rd, 32'h0000_0000);
    axi_wr(4'h2, 32'h0000_0001);  // unmapped write refused
    `CMP(bs, 2'h2);
    axi_rd(4'h0);
    `CMP(rd, 32'h0000_0004);
    $display("test registers done");
    for (int w = 0; w < 4; w++)
    begin
      axi_wr(4'h0, 32'(w) | 32'h0000_0004);
      `CMP(bs, 2'h0);
      for (int i = 0; i < 6; i++)
      begin
        a = edmb_addr_t'(i == 0 ? (256 << w) - 1 : nxt() % (256 << w));
        u_wr(a, nxt(), w);
        u_rd(a);
        `CMP(DOUT, want(a, w));
      end
    end
    $display("test shapes done");
    axi_wr(4'h0, 32'h0000_0004);
    a = edmb_addr_t'(nxt() % 256);
    u_wr(a, nxt(), 0);
    usr_u.step(3'h5, a, nxt(), 3'h0, a);  // tick with clock enable low, write enable high
    u_rd(a);
    `CMP(DOUT, want(a, 0));
    d = nxt();
    usr_u.step(3'h7, a, d, 3'h7, a);
    usr_u.step(3'h0, ~a, ~d, 3'h6, a);
    usr_u.rest();
    `CMP(DOUT, want(a, 0));
    ref_mem[a * 16 +: 16] = d;
    u_rd(a);
    `CMP(DOUT, d);
    $display("test collision done");
    // input/output clocking on separate ports, single port, then input/output clocking alone
    for (int m = 0; m < 3; m++)
    begin
      axi_wr(4'h0, m == 0 ? 32'h0000_000C : 32'(8 * (m - 1)));
      for (int i = 0; i < 4; i++)
      begin
        a = edmb_addr_t'(nxt() % 256);
        u_wr(a, nxt(), 0);
        u_rd(a);
        `CMP(DOUT, want(a, 0));
      end
    end
    $display("test clocking done");
    axi_wr(4'h0, 32'h0000_0017);  // table mode over a narrow shape
    for (int i = 0; i < 4; i++)
    begin
      a = edmb_addr_t'(i * 85);
      d = nxt();
      axi_wr(4'h4, 32'(a));
      axi_wr(4'h8, 32'(d));
      u_wr(a, ~d, 0);
      ref_mem[a * 16 +: 16] = d;
      u_rd(a);
      `CMP(DOUT, d);
    end
    // status: output word, read enable and pending write both idle
    axi_rd(4'hC);
    `CMP(rd, 32'(d));
    axi_rd(4'h4);
    `CMP(rd, 32'(8'(a + 1)));
    axi_rd(4'h8);
    `CMP(rd, 32'(d));
    $display("test table done");
    axi_wr(4'h0, 32'h0000_0024);  // clear pulse, table mode off
    `CMP(bs, 2'h0);
    `CMP(DOUT, 16'h0000);
    axi_rd(4'h0);
    `CMP(rd, 32'h0000_0004);
    u_rd(a);
    `CMP(DOUT, want(a, 0));
    CLR <= 1'b1;
    @(posedge CLK);
    CLR <= 1'b0;
    @(posedge CLK);
    `CMP(DOUT, 16'h0000);
    axi_wr(4'h0, 32'h0000_001B);  // leave control away from its reset
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    axi_rd(4'h0);
    `CMP(rd, 32'h0000_0004);
    $display("test clear done");
    give_verdict();
  end
endmodule : tb
